//--- frc_consts.vh
`ifndef FRC_CONSTS_VH
`define FRC_CONSTS_VH

// instruction codes
`define FRC_OP_SET_READ_PERSIST  8'h65
`define FRC_OP_SET_READ_WORK_A   8'hC0
`define FRC_OP_SET_READ_WORK_B   8'h63
// function register write code: arbitrary, not fixed by the device description
`define FRC_OP_WRITE_FUNCTION    8'h42

// function register fields
`define FRC_FN_RESET_DISABLE     0
`define FRC_FN_BOTTOM_SELECT     1
`define FRC_FN_PROG_SUSPENDED    2
`define FRC_FN_ERASE_SUSPENDED   3
`define FRC_FN_ROW_LOCK_LSB      4
`define FRC_FN_ROW_LOCK_MSB      7
// one-time-programmable bits of the function register
`define FRC_FN_OTP_MASK          8'hF3
`define FRC_FN_RESET_VALUE       8'h00

// read parameter fields
`define FRC_RP_BURST_LSB         0
`define FRC_RP_BURST_MSB         1
`define FRC_RP_WRAP_ENABLE       2
`define FRC_RP_DUMMY_LSB         3
`define FRC_RP_DUMMY_MSB         6
`define FRC_RP_PIN_ROLE          7
`define FRC_RP_RESET_VALUE       8'h00

// burst length codes
`define FRC_BURST_CODE_8         2'h0
`define FRC_BURST_CODE_16        2'h1
`define FRC_BURST_CODE_32        2'h2
`define FRC_BURST_CODE_64        2'h3
`define FRC_BURST_BYTES_8        7'h08
`define FRC_BURST_BYTES_16       7'h10
`define FRC_BURST_BYTES_32       7'h20
`define FRC_BURST_BYTES_64       7'h40

// dummy count used when the field is zero
`define FRC_DUMMY_DEFAULT        4'h8

`endif

//--- frc_regs.v
`timescale 1ns/10ps
`default_nettype none
`include "frc_consts.vh"

module frc_regs #(
    parameter [3:0] DUMMY_DEFAULT = `FRC_DUMMY_DEFAULT
) (
    input  wire       core_clk,
    input  wire       resetn,
    input  wire       por_n,
    input  wire       pkg_dedicated_reset,
    input  wire       cmd_valid,
    input  wire [7:0] cmd_opcode,
    input  wire [7:0] cmd_data,
    input  wire       program_busy,
    input  wire       erase_busy,
    input  wire       suspend_cmd,
    input  wire       resume_cmd,
    input  wire       quad_lines_enable,
    input  wire       four_wire_instruction_mode,
    input  wire [1:0] info_row_sel,
    output wire [7:0] function_otp_status,
    output reg  [7:0] read_params_persistent,
    output reg  [7:0] read_parameters,
    output reg        protect_area_bottom_select,
    output reg  [3:0] info_row_lock,
    output reg        info_row_prog_allowed,
    output reg        reset_on_dedicated_pin,
    output reg        shared_pin_is_pause,
    output reg        shared_pin_is_reset,
    output reg        data_line_three,
    output reg        data_line_two,
    output reg  [3:0] dummy_cycles,
    output reg        wrap_in_burst,
    output reg  [6:0] burst_bytes,
    output reg        load_done
);

    reg        strap_taken;
    // one-time bits and suspend flags live in separate reset domains
    reg  [5:0] otp_bits;
    reg  [1:0] susp_bits;
    reg  [7:0] next_function;
    reg  [7:0] next_persistent;
    reg  [7:0] next_working;
    reg        next_prog_susp;
    reg        next_erase_susp;
    reg  [3:0] dummy_field;
    reg  [6:0] next_burst;
    reg        next_pause;
    reg        next_reset;
    reg        next_line3;
    wire       wr_function;
    wire       wr_persist;
    wire       wr_working;

    assign function_otp_status = {otp_bits[5:2], susp_bits, otp_bits[1:0]};
    assign wr_function = cmd_valid && (cmd_opcode == `FRC_OP_WRITE_FUNCTION);
    assign wr_persist  = cmd_valid && (cmd_opcode == `FRC_OP_SET_READ_PERSIST);
    assign wr_working  = cmd_valid && ((cmd_opcode == `FRC_OP_SET_READ_WORK_A) ||
                                       (cmd_opcode == `FRC_OP_SET_READ_WORK_B));

    always @* begin
        next_function = function_otp_status;
        // bit 0 write sticks once 1
        if (wr_function) begin
            next_function = function_otp_status | (cmd_data & `FRC_FN_OTP_MASK);
        end
        // package default for bit 0, caught after power-on release
        if (!strap_taken) begin
            next_function[`FRC_FN_RESET_DISABLE] = pkg_dedicated_reset ? 1'b0 : 1'b1;
        end
        // set wins over resume in the same cycle
        next_prog_susp = function_otp_status[`FRC_FN_PROG_SUSPENDED];
        if (resume_cmd) begin
            next_prog_susp = 1'b0;
        end
        if (suspend_cmd && program_busy) begin
            next_prog_susp = 1'b1;
        end
        next_erase_susp = function_otp_status[`FRC_FN_ERASE_SUSPENDED];
        if (resume_cmd) begin
            next_erase_susp = 1'b0;
        end
        if (suspend_cmd && erase_busy) begin
            next_erase_susp = 1'b1;
        end
        next_function[`FRC_FN_PROG_SUSPENDED]  = next_prog_susp;
        next_function[`FRC_FN_ERASE_SUSPENDED] = next_erase_susp;
    end

    always @* begin
        next_persistent = wr_persist ? cmd_data : read_params_persistent;
        next_working    = read_parameters;
        // load of the working copy after each resetn release
        if (!load_done) begin
            next_working = read_params_persistent;
        end else if (wr_working) begin
            next_working = cmd_data;
        end
    end

    // persistent copy and one-time bits survive the ordinary reset
    always @(posedge core_clk or negedge por_n) begin
        if (!por_n) begin
            otp_bits                 <= 6'h00;
            read_params_persistent   <= `FRC_RP_RESET_VALUE;
            strap_taken              <= 1'b0;
        end else begin
            otp_bits                 <= {next_function[7:4], next_function[1:0]};
            read_params_persistent   <= next_persistent;
            strap_taken              <= 1'b1;
        end
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            susp_bits                <= 2'h0;
            read_parameters          <= `FRC_RP_RESET_VALUE;
            load_done                <= 1'b0;
        end else begin
            susp_bits                <= next_function[3:2];
            read_parameters          <= next_working;
            load_done                <= 1'b1;
        end
    end

    // dummy count, burst length, wrap and pin role below read the working copy
    always @* begin
        dummy_field = read_parameters[`FRC_RP_DUMMY_MSB:`FRC_RP_DUMMY_LSB];
        if (dummy_field == 4'h0) begin
            dummy_field = DUMMY_DEFAULT;
        end
        case (read_parameters[`FRC_RP_BURST_MSB:`FRC_RP_BURST_LSB])
            `FRC_BURST_CODE_8:  next_burst = `FRC_BURST_BYTES_8;
            `FRC_BURST_CODE_16: next_burst = `FRC_BURST_BYTES_16;
            `FRC_BURST_CODE_32: next_burst = `FRC_BURST_BYTES_32;
            default:            next_burst = `FRC_BURST_BYTES_64;
        endcase
        next_line3 = 1'b0;
        next_pause = 1'b0;
        next_reset = 1'b0;
        // quad or four-wire mode overrides the role bit
        // quad enable makes the pin a data line
        if (quad_lines_enable || four_wire_instruction_mode) begin
            next_line3 = 1'b1;
        end else if (pkg_dedicated_reset && function_otp_status[`FRC_FN_RESET_DISABLE]) begin
            next_reset = 1'b1;
        end else if (pkg_dedicated_reset) begin
            next_pause = 1'b1;
        // role bit picks pause or reset
        end else if (read_parameters[`FRC_RP_PIN_ROLE]) begin
            next_reset = 1'b1;
        end else begin
            next_pause = 1'b1;
        end
    end

    // outputs registered, one cycle behind the registers
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            protect_area_bottom_select <= 1'b0;
            info_row_lock              <= 4'h0;
            info_row_prog_allowed      <= 1'b0;
            reset_on_dedicated_pin     <= 1'b0;
            shared_pin_is_pause        <= 1'b0;
            shared_pin_is_reset        <= 1'b0;
            data_line_three            <= 1'b0;
            data_line_two              <= 1'b0;
            dummy_cycles               <= 4'h0;
            wrap_in_burst              <= 1'b0;
            burst_bytes                <= 7'h00;
        end else begin
            protect_area_bottom_select <= function_otp_status[`FRC_FN_BOTTOM_SELECT];
            info_row_lock              <= function_otp_status[`FRC_FN_ROW_LOCK_MSB:`FRC_FN_ROW_LOCK_LSB];
            info_row_prog_allowed      <= ~function_otp_status[`FRC_FN_ROW_LOCK_LSB + info_row_sel];
            reset_on_dedicated_pin     <= pkg_dedicated_reset & ~function_otp_status[`FRC_FN_RESET_DISABLE];
            shared_pin_is_pause        <= next_pause;
            shared_pin_is_reset        <= next_reset;
            data_line_three            <= next_line3;
            // protect pin becomes data line two
            data_line_two              <= quad_lines_enable | four_wire_instruction_mode;
            dummy_cycles               <= dummy_field;
            wrap_in_burst              <= read_parameters[`FRC_RP_WRAP_ENABLE];
            burst_bytes                <= next_burst;
        end
    end

endmodule
`default_nettype wire

//--- frc_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module frc_regs_props #(
    parameter [3:0] DUMMY_DEFAULT = 4'h8
) (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       por_n,
    input wire logic       pkg_dedicated_reset,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic [7:0] cmd_data,
    input wire logic       program_busy,
    input wire logic       suspend_cmd,
    input wire logic       resume_cmd,
    input wire logic       quad_lines_enable,
    input wire logic       four_wire_instruction_mode,
    input wire logic [7:0] function_otp_status,
    input wire logic [7:0] read_params_persistent,
    input wire logic [7:0] read_parameters,
    input wire logic       shared_pin_is_reset,
    input wire logic [3:0] dummy_cycles,
    input wire logic [6:0] burst_bytes,
    input wire logic       load_done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    prog_susp_a: assert property (
        suspend_cmd && program_busy |=> function_otp_status[2]) else $error("suspend flag not set");
    resume_clear_a: assert property (
        resume_cmd && !suspend_cmd |=> function_otp_status[3:2] == 2'h0) else $error("resume did not clear");
    otp_sticky_a: assert property (
        disable iff (!por_n) ($past(function_otp_status) & ~function_otp_status & 8'hF3) == 8'h00)
        else $error("one-time bit fell");
    persist_write_a: assert property (
        disable iff (!por_n) cmd_valid && cmd_opcode == 8'h65 |=> read_params_persistent == $past(cmd_data))
        else $error("persistent write lost");
    working_write_a: assert property (
        load_done && cmd_valid && (cmd_opcode == 8'hC0 || cmd_opcode == 8'h63)
        |=> read_parameters == $past(cmd_data)) else $error("working write lost");
    burst_len_a: assert property (
        load_done |=> burst_bytes == (7'h08 << $past(read_parameters[1:0]))) else $error("burst length");
    dummy_count_a: assert property (
        load_done |=> dummy_cycles == (($past(read_parameters[6:3]) == 4'h0) ? DUMMY_DEFAULT
        : $past(read_parameters[6:3]))) else $error("dummy count");
    pin_role_a: assert property (
        load_done && !quad_lines_enable && !four_wire_instruction_mode && !pkg_dedicated_reset
        |=> shared_pin_is_reset == $past(read_parameters[7])) else $error("shared pin role");
endmodule
bind frc_regs frc_regs_props #(.DUMMY_DEFAULT(DUMMY_DEFAULT)) i_frc_regs_props (.*);
`default_nettype wire

//--- frc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module frc_host_model (
    input  wire logic core_clk,
    output var logic  cmd_valid,
    output var logic  [7:0] cmd_opcode,
    output var logic  [7:0] cmd_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        cmd_data = 8'h00;
    end
    task automatic send(input logic [7:0] op, input logic [7:0] d);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_opcode = op;
        cmd_data = d;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        // released bus shows inverted leftovers, never the old byte
        cmd_opcode = ~op;
        cmd_data = ~d;
    endtask
endmodule
`default_nettype wire

//--- frc_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module frc_regs_tb_top;
    logic        core_clk = 1'b0, resetn = 1'b0, por_n = 1'b0, pkg_dedicated_reset = 1'b0;
    logic        program_busy = 1'b0, erase_busy = 1'b0, suspend_cmd = 1'b0, resume_cmd = 1'b0;
    logic        quad_lines_enable = 1'b0, four_wire_instruction_mode = 1'b0;
    logic [1:0]  info_row_sel = 2'h0;
    wire         cmd_valid, protect_area_bottom_select, info_row_prog_allowed, reset_on_dedicated_pin;
    wire         shared_pin_is_pause, shared_pin_is_reset, data_line_three, data_line_two, wrap_in_burst, load_done;
    wire  [7:0]  cmd_opcode, cmd_data, function_otp_status, read_params_persistent, read_parameters;
    wire  [3:0]  info_row_lock, dummy_cycles;
    wire  [6:0]  burst_bytes;
    int          failures = 0, comparisons = 0, cycles = 0;
    // data, burst bytes, dummy count, wrap
    logic [19:0] rows [4] = '{20'h00110, 20'h0D203, 20'h7A41E, 20'h47811};
    frc_regs i_frc_regs (.*);
    frc_host_model i_frc_host_model (.*);
    initial forever #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // extra edge lets the derived outputs follow
    task automatic cmd(input logic [7:0] op, input logic [7:0] d);
        i_frc_host_model.send(op, d);
        @(negedge core_clk);
    endtask
    task automatic boot(input logic por, input logic strap);
        pkg_dedicated_reset = strap;
        resetn = 1'b0;
        por_n = ~por;
        repeat (3) @(negedge core_clk);
        resetn = 1'b1;
        por_n = 1'b1;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic pulse(input logic s, input logic r);
        suspend_cmd = s;
        resume_cmd = r;
        @(negedge core_clk);
        suspend_cmd = 1'b0;
        resume_cmd = 1'b0;
        @(negedge core_clk);
    endtask
    initial begin
        @(negedge core_clk);
        boot(1'b1, 1'b0);
        chk(function_otp_status, 8'h01);
        chk(read_parameters, 8'h00);
        chk(8'(load_done), 8'h01);
        foreach (rows[i]) begin
            cmd(i[0] ? 8'h63 : 8'hC0, rows[i][19:12]);
            chk(read_parameters, rows[i][19:12]);
            chk(8'(burst_bytes), 8'(rows[i][11:5]));
            chk(8'(dummy_cycles), 8'(rows[i][4:1]));
            chk(8'(wrap_in_burst), 8'(rows[i][0]));
        end
        cmd(8'h65, 8'h80);
        chk(read_params_persistent, 8'h80);
        chk({read_parameters[7:1], shared_pin_is_reset}, 8'h46);
        boot(1'b0, 1'b0);
        chk(read_parameters, 8'h80);
        chk({function_otp_status[6:0], shared_pin_is_reset}, 8'h03);
        for (int m = 1; m < 4; m++) begin
            {four_wire_instruction_mode, quad_lines_enable} = m[1:0];
            @(negedge core_clk);
            chk({5'h00, shared_pin_is_reset, data_line_three, data_line_two}, 8'h03);
        end
        {four_wire_instruction_mode, quad_lines_enable} = 2'h0;
        cmd(8'h42, 8'h12);
        @(negedge core_clk);
        chk({info_row_lock, 2'h0, protect_area_bottom_select, info_row_prog_allowed}, 8'h12);
        info_row_sel = 2'h1;
        @(negedge core_clk);
        chk(8'(info_row_prog_allowed), 8'h01);
        cmd(8'h42, 8'h0C);
        chk(function_otp_status, 8'h13);
        cmd(8'h42, 8'hE0);
        chk(function_otp_status, 8'hF3);
        program_busy = 1'b1;
        pulse(1'b1, 1'b0);
        chk(function_otp_status, 8'hF7);
        pulse(1'b1, 1'b1);
        chk(function_otp_status, 8'hF7);
        pulse(1'b0, 1'b1);
        chk(function_otp_status, 8'hF3);
        program_busy = 1'b0;
        erase_busy = 1'b1;
        pulse(1'b1, 1'b0);
        chk(function_otp_status, 8'hFB);
        pulse(1'b0, 1'b1);
        chk(function_otp_status, 8'hF3);
        boot(1'b1, 1'b1);
        chk({function_otp_status[6:0], reset_on_dedicated_pin}, 8'h01);
        cmd(8'hC0, 8'h80);
        chk(8'(shared_pin_is_pause), 8'h01);
        cmd(8'h42, 8'h01);
        chk({6'h00, reset_on_dedicated_pin, shared_pin_is_reset}, 8'h01);
        cmd(8'h42, 8'h00);
        chk(function_otp_status, 8'h01);
        tally_and_finish();
    end
endmodule
`default_nettype wire
